// File: drc_defs.svh
/*
 * Shared constants for the drive run/stop control block.
 * Assumes a single 250 MHz clock and a synchronous active-low reset.
 */
`ifndef DRC_DEFS_SVH
`define DRC_DEFS_SVH
// ------------------------------------------------------------
// Overview of operation
// R1: frequency command is first, first plus second, or first minus second
// R2: stop setting picks ramp or coast for stop command and external fault
// R3: switch two on forces stop setting to 1 and blocks writes
// R4: ramp stop decelerates to minimum frequency, then output ceases
// R5: coast stop shuts output off at once
// R6: carrier selectable 1 to 15 kHz in 1 kHz steps, reset 8 kHz
// R7: carrier lowered automatically when heat sink and current are high
// R8: direction setting: 0 both, 1 no reverse, 2 no forward
// R9: terminal run held at power-up starts at once for lockout 0/2 only; lockout resets to 1, so a held run never starts at once
// R10: source change to terminals adopts terminal state for lockout 2/3
// R11: source-change handling only when new source 1/2 and states differ
// R12: operation command source resets to 1
// R13: source 1 terminals with keypad stop, source 2 keypad stop ignored
// R14: negative difference clamps to zero
// R15: out-of-range setting writes are ignored, except combination and direction, which do not check wdata[3:2]
// ------------------------------------------------------------
`define DRC_A_COMB 3'h0
`define DRC_A_STOP 3'h1
`define DRC_A_CARR 3'h2
`define DRC_A_DIR 3'h3
`define DRC_A_LOCK 3'h4
`define DRC_A_SRC 3'h5
`define DRC_A_STAT 3'h6
`define DRC_A_FOUT 3'h7
`define DRC_COMB_MAX 2'h2
`define DRC_DIR_MAX 2'h2
`define DRC_SRC_MAX 3'h5
`define DRC_CARR_MIN 4'h1
`define DRC_CARR_MAX 4'hF
`define DRC_CARR_RST 4'h8
`define DRC_CARR_DERATE 4'h3
`define DRC_STOP_RST 2'h0
`define DRC_STOP_FORCED 2'h1
`define DRC_LOCK_RST 2'h1
`define DRC_SRC_RST 3'h1
`define DRC_SRC_TERM_KS 3'h1
`define DRC_SRC_TERM_NS 3'h2
`define DRC_CLK_KHZ 250000
`endif

// File: drc_pkg.sv
/*
 * Types for the drive run/stop control block.
 * Assumes drc_defs.svh is compiled alongside.
 */
package drc_pkg;
   typedef enum logic [3:0] {
      DRC_IDLE = 4'h1,
      DRC_RUN = 4'h2,
      DRC_RAMP = 4'h4,
      DRC_HOLD = 4'h8
   } drc_state_t;
   typedef struct packed {
      logic stop_coast;
      logic fault_coast;
   } drc_stop_sel_t;
endpackage

// File: drc_carrier.sv
/*
 * PWM carrier generator: divides ref_clk to 1..15 kHz.
 * Assumes a 250 MHz clock.
 */
`include "drc_defs.svh"
module drc_carrier #(
   parameter int CLK_KHZ = `DRC_CLK_KHZ
) (
   input wire logic ref_clk, // system clock
   input wire logic resetn, // sync reset, low
   input wire logic [3:0] khz, // carrier in kHz, 1..15
   output logic pwm_carrier // square carrier
);
   logic [17:0] cnt;
   logic [17:0] half;
   always_comb begin
      half = 18'(CLK_KHZ / 2 / ((khz == 4'h0) ? 1 : int'(khz)));
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt <= 18'h00000;
         pwm_carrier <= 1'b0;
      end else if (cnt + 18'h00001 >= half) begin // R6
         cnt <= 18'h00000;
         pwm_carrier <= ~pwm_carrier;
      end else begin
         cnt <= cnt + 18'h00001;
      end
   end
endmodule // drc_carrier

// File: drc_run_stop.sv
/*
 * Run/stop command control: frequency combine, stop method, carrier,
 * direction inhibit and line start lockout, behind a plain register port.
 * Assumes terminal pins are asynchronous; register port is synchronous.
 */
`include "drc_defs.svh"
module drc_run_stop #(
   parameter int FW = 16, // frequency width
   parameter logic [FW-1:0] DECEL_STEP = 16'h0001 // per-cycle ramp step
) (
   input wire logic ref_clk, // 250 MHz clock
   input wire logic resetn, // sync reset, low
   input wire logic [2:0] addr, // register address
   input wire logic [15:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [15:0] rdata, // read data, cycle after rd
   input wire logic forward_run_terminal, // terminal forward run, async
   input wire logic reverse_run_terminal, // terminal reverse run, async
   input wire logic cfg_switch2, // switch two, async
   input wire logic ext_fault, // external fault, async
   input wire logic keypad_run, // keypad/serial run, same clock
   input wire logic keypad_stop, // keypad stop/reset, same clock
   input wire logic keypad_rev, // keypad/serial reverse request
   input wire logic therm_high, // heat sink hot, async
   input wire logic current_high, // output current high, async
   input wire logic [FW-1:0] freq_first, // first master frequency
   input wire logic [FW-1:0] freq_second, // second master frequency
   input wire logic [FW-1:0] freq_min, // minimum output frequency
   output logic [FW-1:0] out_freq, // output frequency
   output logic out_enable, // output stage enabled
   output logic out_reverse, // reverse rotation
   output logic pwm_carrier // carrier square wave
);
   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // no reset: pin levels must be settled when reset lifts, for the lockout
   logic [5:0] sync1, sync2;
   always_ff @(posedge ref_clk) begin
      sync1 <= {forward_run_terminal, reverse_run_terminal, cfg_switch2,
                ext_fault, therm_high, current_high};
      sync2 <= sync1;
   end
   logic t_fwd, t_rev, sw2, fault, hot, cur;
   assign {t_fwd, t_rev, sw2, fault, hot, cur} = sync2;
   logic term_run;
   assign term_run = t_fwd | t_rev;

   // ------------------------------------------------------------
   // settings
   // ------------------------------------------------------------
   logic [1:0] comb_sel, stop_sel, dir_sel, lock_sel;
   logic [3:0] carr_sel;
   logic [2:0] src_sel;
   logic wr_ok;
   assign wr_ok = wr && wdata[15:4] == 12'h000;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         comb_sel <= 2'h0;
         dir_sel <= 2'h0;
         lock_sel <= `DRC_LOCK_RST;
         carr_sel <= `DRC_CARR_RST; // R6
         src_sel <= `DRC_SRC_RST; // R12
      end else if (wr_ok) begin
         if (addr == `DRC_A_COMB && wdata[1:0] <= `DRC_COMB_MAX) // R15
            comb_sel <= wdata[1:0];
         if (addr == `DRC_A_DIR && wdata[1:0] <= `DRC_DIR_MAX) // R15
            dir_sel <= wdata[1:0];
         if (addr == `DRC_A_LOCK && wdata[3:2] == 2'h0) // R15
            lock_sel <= wdata[1:0];
         if (addr == `DRC_A_CARR && wdata[3:0] >= `DRC_CARR_MIN) // R6
            carr_sel <= wdata[3:0];
         if (addr == `DRC_A_SRC && wdata[2:0] <= `DRC_SRC_MAX && !wdata[3])
            src_sel <= wdata[2:0];
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         stop_sel <= `DRC_STOP_RST;
      end else if (sw2) begin
         stop_sel <= `DRC_STOP_FORCED; // R3
      end else if (wr_ok && addr == `DRC_A_STOP && wdata[3:2] == 2'h0) begin // R15
         stop_sel <= wdata[1:0];
      end
   end
   drc_pkg::drc_stop_sel_t stop_mode;
   always_comb begin
      case (stop_sel) // R2
         2'h0: stop_mode = '{stop_coast: 1'b0, fault_coast: 1'b1};
         2'h1: stop_mode = '{stop_coast: 1'b1, fault_coast: 1'b1};
         2'h2: stop_mode = '{stop_coast: 1'b0, fault_coast: 1'b0};
         default: stop_mode = '{stop_coast: 1'b1, fault_coast: 1'b0};
      endcase
   end

   // ------------------------------------------------------------
   // frequency command
   // ------------------------------------------------------------
   logic [FW:0] sum;
   logic [FW-1:0] freq_cmd;
   always_comb begin
      sum = {1'b0, freq_first} + {1'b0, freq_second};
      case (comb_sel) // R1
         2'h1: freq_cmd = sum[FW] ? {FW{1'b1}} : sum[FW-1:0];
         2'h2: freq_cmd = (freq_second > freq_first) ? '0 // R14
                          : freq_first - freq_second;
         default: freq_cmd = freq_first;
      endcase
   end

   // ------------------------------------------------------------
   // run request and lockout
   // ------------------------------------------------------------
   logic src_term, src_term_d, ks_ok, armed, powerup, term_run_d, keep_run;
   assign src_term = src_sel == `DRC_SRC_TERM_KS || src_sel == `DRC_SRC_TERM_NS;
   assign ks_ok = src_sel != `DRC_SRC_TERM_NS && src_sel != 3'h4 && src_sel != 3'h5; // R13
   logic want_rev, dir_block;
   assign want_rev = src_term ? (t_rev & ~t_fwd) : keypad_rev;
   assign dir_block = (dir_sel == 2'h1 && want_rev) || (dir_sel == 2'h2 && !want_rev); // R8
   logic run_req;
   assign run_req = src_term ? ((term_run && armed) || keep_run) : keypad_run;
   logic stop_req;
   assign stop_req = !run_req || dir_block || (keypad_stop && ks_ok);

   drc_pkg::drc_state_t state;
   logic running;
   assign running = state == drc_pkg::DRC_RUN;
   logic src_chg;
   assign src_chg = src_term && !src_term_d && !powerup && (term_run != running); // R11
   // lockout 0/1 keeps a running drive going until the terminal moves
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         keep_run <= 1'b0;
      end else if (src_chg) begin
         keep_run <= running && !lock_sel[1]; // R10
      end else if (!src_term || term_run != term_run_d || (keypad_stop && ks_ok)) begin
         keep_run <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         src_term_d <= 1'b0;
         powerup <= 1'b1;
         term_run_d <= 1'b0;
      end else begin
         src_term_d <= src_term;
         powerup <= 1'b0;
         term_run_d <= term_run;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         armed <= 1'b0;
      end else if (powerup) begin
         armed <= !(term_run && lock_sel[0]); // R9
      end else if (src_chg) begin
         armed <= lock_sel[1] || !term_run; // R10
      end else if (!term_run) begin
         armed <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // run/stop state machine
   // ------------------------------------------------------------
   logic coast_now, ramp_now;
   assign coast_now = (fault && stop_mode.fault_coast) ||
                      (!fault && stop_req && stop_mode.stop_coast);
   assign ramp_now = fault || stop_req;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state <= drc_pkg::DRC_IDLE;
      end else begin
         case (state)
            drc_pkg::DRC_IDLE: if (!ramp_now && !powerup) state <= drc_pkg::DRC_RUN;
            drc_pkg::DRC_RUN: begin
               if (coast_now) state <= drc_pkg::DRC_IDLE; // R5
               else if (ramp_now) state <= drc_pkg::DRC_RAMP; // R4
            end
            drc_pkg::DRC_RAMP: begin
               if (coast_now) state <= drc_pkg::DRC_IDLE; // R5
               else if (out_freq <= freq_min) state <= drc_pkg::DRC_HOLD; // R4
            end
            drc_pkg::DRC_HOLD: state <= drc_pkg::DRC_IDLE;
            default: state <= drc_pkg::DRC_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // output stage
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         out_freq <= '0;
         out_enable <= 1'b0;
         out_reverse <= 1'b0;
      end else begin
         case (state)
            drc_pkg::DRC_RUN: begin
               out_enable <= !coast_now; // R5
               out_freq <= coast_now ? '0 : freq_cmd;
               if (!ramp_now) out_reverse <= want_rev;
            end
            drc_pkg::DRC_RAMP: begin
               out_enable <= !coast_now;
               if (coast_now) out_freq <= '0;
               else if (out_freq > freq_min + DECEL_STEP)
                  out_freq <= out_freq - DECEL_STEP; // R4
               else out_freq <= freq_min;
            end
            default: begin
               out_enable <= 1'b0;
               out_freq <= '0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // carrier with derating
   // ------------------------------------------------------------
   logic [3:0] carr_eff;
   always_ff @(posedge ref_clk) begin
      if (!resetn) carr_eff <= `DRC_CARR_RST;
      else if (hot && cur && carr_sel > `DRC_CARR_DERATE)
         carr_eff <= carr_sel - `DRC_CARR_DERATE; // R7
      else if (hot && cur) carr_eff <= `DRC_CARR_MIN; // R7
      else carr_eff <= carr_sel;
   end
   drc_carrier u_carrier (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .khz(carr_eff),
      .pwm_carrier(pwm_carrier)
   );

   // ------------------------------------------------------------
   // read port
   // ------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (!resetn) rdata <= 16'h0000;
      else if (rd) begin
         case (addr)
            `DRC_A_COMB: rdata <= {14'h0000, comb_sel};
            `DRC_A_STOP: rdata <= {14'h0000, stop_sel};
            `DRC_A_CARR: rdata <= {8'h00, carr_eff, carr_sel};
            `DRC_A_DIR: rdata <= {14'h0000, dir_sel};
            `DRC_A_LOCK: rdata <= {14'h0000, lock_sel};
            `DRC_A_SRC: rdata <= {13'h0000, src_sel};
            `DRC_A_STAT: rdata <= {8'h00, state, armed, sw2, out_enable, out_reverse};
            default: rdata <= out_freq[15:0];
         endcase
      end else rdata <= 16'h0000;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sw_force_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R3
      $past(sw2) |-> stop_sel == `DRC_STOP_FORCED) else $error("stop not forced");
   coast_off_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R5
      running && coast_now |=> !out_enable) else $error("coast kept output");
   ramp_floor_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R4
      state == drc_pkg::DRC_RAMP && out_enable |-> out_freq >= freq_min)
      else $error("ramp below minimum");
   diff_clamp_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
      comb_sel == 2'h2 && freq_second > freq_first |-> freq_cmd == '0)
      else $error("difference not clamped");
   comb_range_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R15
      comb_sel <= `DRC_COMB_MAX) else $error("combination out of range");
   dir_range_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R8
      running && out_enable && dir_sel == 2'h1 |-> !out_reverse)
      else $error("reverse ran while blocked");
   carr_range_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R6
      carr_sel >= `DRC_CARR_MIN) else $error("carrier out of range");
   derate_a: assert property (@(posedge ref_clk) disable iff (!resetn) // R7
      hot && cur ##1 1'b1 |-> carr_eff < carr_sel || carr_eff == `DRC_CARR_MIN)
      else $error("carrier not derated");
   cv_ramp: cover property (@(posedge ref_clk) state == drc_pkg::DRC_HOLD);
   cv_coast: cover property (@(posedge ref_clk) running && coast_now);
   cv_srcchg: cover property (@(posedge ref_clk) src_chg);
endmodule // drc_run_stop

// File: drc_stage_model.sv
/*
 * Far-side model: command contacts, fault contact and a motor load.
 * Assumes the bench drives the cmd_ inputs just after a rising edge.
 */
module drc_stage_model (
   input wire logic ref_clk, // system clock
   input wire logic out_enable, // stage enabled
   input wire logic [15:0] out_freq, // output frequency
   input wire logic cmd_fwd, // close forward contact
   input wire logic cmd_rev, // close reverse contact
   input wire logic cmd_fault, // raise external fault
   output logic forward_run_terminal, // forward contact level
   output logic reverse_run_terminal, // reverse contact level
   output logic ext_fault, // fault contact level
   output logic [15:0] motor_speed = 16'h0000 // rotor speed
);
   timeunit 1ns;
   timeprecision 1ps;
   assign forward_run_terminal = cmd_fwd;
   assign reverse_run_terminal = cmd_rev;
   assign ext_fault = cmd_fault;
   // driven rotor follows the stage, otherwise it runs down freely
   always @(posedge ref_clk) begin
      if (out_enable) begin
         motor_speed <= out_freq;
      end else if (motor_speed != 16'h0000) begin
         motor_speed <= motor_speed - 16'h0001;
      end
   end
endmodule // drc_stage_model

// File: drive_run_stop_control_tb.sv
/*
 * Self-checking bench for drc_run_stop with the far-side model.
 * Assumes a 250 MHz clock, sync active-low reset, default DECEL_STEP.
 */
module drive_run_stop_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [15:0] wdata = 16'h0000, rdata, out_freq, v, spd;
   logic cmd_fwd = 1'b1, cmd_rev = 1'b0, cmd_fault = 1'b0, sw2 = 1'b0;
   logic k_run = 1'b0, k_stop = 1'b0, t_hi = 1'b0, i_hi = 1'b0;
   logic [15:0] f1 = 16'h0040, f2 = 16'h0010, fmin = 16'h0010;
   logic fwd_t, rev_t, fault_t, out_enable, out_reverse, pwm_carrier;
   logic [15:0] rst_exp [6] = '{16'h0000, 16'h0000, 16'h0088, 16'h0000, 16'h0001, 16'h0001};
   int n_errors = 0, check_count = 0;
   time t0;
   always #2 ref_clk = ~ref_clk;
   drc_run_stop uut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .forward_run_terminal(fwd_t), .reverse_run_terminal(rev_t),
      .cfg_switch2(sw2), .ext_fault(fault_t), .keypad_run(k_run), .keypad_stop(k_stop),
      .keypad_rev(1'b0), .therm_high(t_hi), .current_high(i_hi), .freq_first(f1),
      .freq_second(f2), .freq_min(fmin), .out_freq(out_freq), .out_enable(out_enable),
      .out_reverse(out_reverse), .pwm_carrier(pwm_carrier));
   drc_stage_model stage (.ref_clk(ref_clk), .out_enable(out_enable), .out_freq(out_freq),
      .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev), .cmd_fault(cmd_fault),
      .forward_run_terminal(fwd_t), .reverse_run_terminal(rev_t), .ext_fault(fault_t),
      .motor_speed(spd));
   // ------------------------------------------------------------
   // bus and check tasks
   // ------------------------------------------------------------
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task wreg(input logic [2:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task rreg(input logic [2:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task chk1(input logic got, input logic exp);
      chk({15'h0000, got}, {15'h0000, exp});
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenario tasks
   // ------------------------------------------------------------
   task stop_case(input logic [1:0] m, input logic by_fault);
      logic coast;
      coast = by_fault ? (m < 2'h2) : m[0];
      wreg(3'h1, {14'h0000, m});
      cmd_fwd <= 1'b1;
      cyc(12);
      if (by_fault) cmd_fault <= 1'b1;
      else cmd_fwd <= 1'b0;
      cyc(6);
      chk1(out_enable, ~coast);
      if (coast) chk1(spd != 16'h0000, 1'b1);
      if (!coast) chk1(out_freq < 16'h0040, 1'b1);
      cyc(100);
      chk1(out_enable, 1'b0);
      cmd_fault <= 1'b0;
      cmd_fwd <= 1'b0;
      k_stop <= 1'b1;
      cyc(1);
      k_stop <= 1'b0;
      cyc(5);
   endtask
   task dir_case(input logic [1:0] d, input logic rv, input logic en);
      wreg(3'h3, {14'h0000, d});
      cmd_rev <= rv;
      cmd_fwd <= ~rv;
      cyc(10);
      chk1(out_enable, en);
      if (en) chk1(out_reverse, rv);
      cmd_rev <= 1'b0;
      cmd_fwd <= 1'b0;
      cyc(110);
   endtask
   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      cyc(4);
      resetn <= 1'b1;
      cyc(10);
      chk1(out_enable, 1'b0);
      for (int i = 0; i < 6; i++) begin
         rreg(3'(i), v);
         chk(v, rst_exp[i]);
      end
      cmd_fwd <= 1'b0;
      cyc(5);
      cmd_fwd <= 1'b1;
      cyc(10);
      chk1(out_enable, 1'b1);
      chk(out_freq, 16'h0040);
      $display("reset and power-up test done");
      wreg(3'h0, 16'h0001);
      cyc(8);
      chk(out_freq, 16'h0050);
      wreg(3'h0, 16'h0002);
      cyc(8);
      chk(out_freq, 16'h0030);
      f2 <= 16'h0050;
      cyc(8);
      chk(out_freq, 16'h0000);
      wreg(3'h0, 16'h0003);
      rreg(3'h0, v);
      chk(v, 16'h0002);
      wreg(3'h0, 16'h0000);
      f2 <= 16'h0010;
      $display("combine test done");
      t_hi <= 1'b1;
      i_hi <= 1'b1;
      cyc(5);
      rreg(3'h2, v);
      chk(v, 16'h0058);
      wreg(3'h2, 16'h000F);
      wreg(3'h2, 16'h0000);
      rreg(3'h2, v);
      chk(v, 16'h00CF);
      i_hi <= 1'b0;
      cyc(5);
      rreg(3'h2, v);
      chk(v, 16'h00FF);
      @(pwm_carrier);
      t0 = $time;
      @(pwm_carrier);
      chk(16'(($time - t0) / 4), 16'h208D);
      t_hi <= 1'b0;
      wreg(3'h2, 16'h0008);
      $display("carrier test done");
      sw2 <= 1'b1;
      cyc(5);
      rreg(3'h1, v);
      chk(v, 16'h0001);
      wreg(3'h1, 16'h0002);
      rreg(3'h1, v);
      chk(v, 16'h0001);
      sw2 <= 1'b0;
      cyc(5);
      wreg(3'h1, 16'h0002);
      rreg(3'h1, v);
      chk(v, 16'h0002);
      $display("switch test done");
      cmd_fwd <= 1'b0;
      cyc(110);
      for (int m = 0; m < 4; m++) begin
         stop_case(2'(m), 1'b0);
         stop_case(2'(m), 1'b1);
      end
      $display("stop method test done");
      dir_case(2'h1, 1'b1, 1'b0);
      dir_case(2'h2, 1'b1, 1'b1);
      dir_case(2'h2, 1'b0, 1'b0);
      dir_case(2'h0, 1'b0, 1'b1);
      $display("direction test done");
      wreg(3'h5, 16'h0000);
      k_run <= 1'b1;
      cyc(10);
      chk1(out_enable, 1'b1);
      wreg(3'h4, 16'h0000);
      wreg(3'h5, 16'h0001);
      cyc(10);
      chk1(out_enable, 1'b1);
      wreg(3'h5, 16'h0000);
      wreg(3'h4, 16'h0003);
      wreg(3'h5, 16'h0002);
      cyc(120);
      chk1(out_enable, 1'b0);
      cmd_fwd <= 1'b1;
      k_stop <= 1'b1;
      cyc(10);
      chk1(out_enable, 1'b1);
      wreg(3'h5, 16'h0001);
      cyc(120);
      chk1(out_enable, 1'b0);
      k_stop <= 1'b0;
      $display("source change test done");
      conclude();
   end
   initial begin
      #200000;
      n_errors++;
      conclude();
   end
endmodule // drive_run_stop_control_tb
